// *** design/dcl_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module dcl_top
#(
	parameter int unsigned FLICKER_HALF = dcl_pkg::FLICKER_HALF_CYC,
	parameter int unsigned FLASH_HALF   = dcl_pkg::FLASH_HALF_CYC,
	parameter int unsigned IDENT_LEN    = dcl_pkg::IDENT_CYC,
	parameter int unsigned RESTORE_LEN  = dcl_pkg::RESTORE_CYC
)
(
	input  wire logic                   clock,
	input  wire logic                   rst_n,
	input  wire logic                   switches_fitted,
	input  wire logic [9:0]             switch_value,
	input  wire logic [1:0]             port_link,
	input  wire logic [1:0]             port_traffic,
	input  wire logic                   motor_supply_ok,
	input  wire logic                   net_connected,
	input  wire logic                   cyclic_active,
	input  wire logic                   identify_req,
	input  wire logic                   watchdog_timeout,
	input  wire logic                   system_fault,
	input  wire logic                   diag_pending,
	input  wire logic                   delivery_state,
	input  wire logic [15:0]            stored_address,
	input  wire dcl_pkg::dcl_cmd_t      cyclic_cmd,
	input  wire dcl_pkg::dcl_cmd_t      explicit_cmd,
	input  wire logic [31:0]            actual_pos,
	input  wire logic                   target_reached,
	input  wire logic [15:0]            loop_setting,
	input  wire dcl_pkg::dcl_pwr_t      acyc_write,
	input  wire dcl_pkg::dcl_prd_t      acyc_read,
	output logic [1:0]                  link_lamp_q,
	output logic [1:0]                  activity_lamp_q,
	output logic                        bus_fault_lamp_q,
	output logic                        status_fault_lamp_q,
	output logic                        motor_lamp_q,
	output dcl_pkg::dcl_name_src_t      name_source_q,
	output logic [15:0]                 name_number_q,
	output dcl_pkg::dcl_motion_t        motion_q,
	output logic                        manual_fwd_q,
	output logic [31:0]                 target_q,
	output logic                        run_start_q,
	output logic                        run_abort_q,
	output logic                        retarget_q,
	output logic                        no_stop_q,
	output logic                        loop_enable_q,
	output logic                        loop_fwd_q,
	output logic [15:0]                 loop_length_q,
	output logic                        factory_restore_q,
	output logic                        restore_window_q,
	output logic [15:0]                 status_word_q,
	output dcl_pkg::dcl_pexec_t         param_exec_q,
	output logic                        read_done_q,
	output logic [2:0]                  read_len_q
);
	import dcl_pkg::*;

	typedef struct packed
	{
		logic [9:0]    sw_s1;
		logic [9:0]    sw_s2;
		logic          fit_s1;
		logic          fit_s2;
		logic [1:0]    link_s1;
		logic [1:0]    link_s2;
		logic [1:0]    traf_s1;
		logic [1:0]    traf_s2;
		logic          mot_s1;
		logic          mot_s2;
		logic [1:0]    samp_cnt;
		logic          sampled;
		dcl_name_src_t name_src;
		logic [15:0]   name_num;
		logic          restore_win;
		logic [27:0]   restore_cnt;
		logic          restore;
		logic [27:0]   ident_cnt;
		logic [1:0]    link_lamp;
		logic [1:0]    act_lamp;
		logic          bf_lamp;
		logic          sf_lamp;
		logic          mot_lamp;
		dcl_motion_t   motion;
		logic          man_fwd;
		logic          dir_fwd;
		logic          loaded;
		logic [31:0]   target;
		logic          start;
		logic          abort;
		logic          retarget;
		logic          no_stop;
		logic          aborted;
		logic          loop_en;
		logic          loop_fwd;
		logic [15:0]   loop_len;
		dcl_pexec_t    pexec;
		logic          rd_done;
		logic [2:0]    rd_len;
		logic [15:0]   status;
	} dcl_state_t;

	dcl_state_t q;
	dcl_state_t d;
	logic       flicker;
	logic       flash;

	dcl_blink #(.HALF_CYC(FLICKER_HALF)) u_flicker
	(
		.clock  (clock),
		.rst_n  (rst_n),
		.wave_q (flicker)
	);
	dcl_blink #(.HALF_CYC(FLASH_HALF)) u_flash
	(
		.clock  (clock),
		.rst_n  (rst_n),
		.wave_q (flash)
	);
	dcl_cmd_t cmd;
	logic     rel;
	logic     tv;
	logic     fwd;
	logic     rev;
	logic     new_dir;

	always_comb
	begin
		// Cyclic commands while connected, explicit ones only without it
		cmd = cyclic_active ? cyclic_cmd : explicit_cmd;
		rel = cmd.control[CW_RELEASE];
		tv  = cmd.control[CW_TARGET];
		fwd = cmd.control[CW_FWD];
		rev = cmd.control[CW_REV];
		new_dir = $signed(cmd.target) > $signed(actual_pos);
		d = q;
		{d.sw_s1, d.fit_s1, d.link_s1, d.traf_s1, d.mot_s1} =
			{switch_value, switches_fitted, port_link, port_traffic, motor_supply_ok};
		{d.sw_s2, d.fit_s2, d.link_s2, d.traf_s2, d.mot_s2} =
			{q.sw_s1, q.fit_s1, q.link_s1, q.traf_s1, q.mot_s1};
		{d.start, d.abort, d.retarget, d.restore, d.pexec.write, d.rd_done} = 6'h00;
		// One switch sample after the synchroniser has settled
		if (!q.sampled)
		begin
			if (q.samp_cnt != SAMPLE_WAIT)
				d.samp_cnt = q.samp_cnt + 2'h1;
			else
			begin
				d.sampled = 1'b1;
				if (q.fit_s2 && q.sw_s2 != '0)
				begin
					d.name_src = NS_SWITCH;
					d.name_num = {6'h00, q.sw_s2};
				end
				else if (stored_address != '0)
				begin
					d.name_src = NS_STORED;
					d.name_num = stored_address;
				end
				else
				begin
					d.name_src = NS_ASSIGNED;
					d.name_num = '0;
				end
				if (q.fit_s2 && q.sw_s2 == SW_RESTORE_ARM)
				begin
					d.restore_win = 1'b1;
					d.restore_cnt = 28'(RESTORE_LEN - 1);
				end
			end
		end

		// Restore window, cut short by communication
		if (q.restore_win)
		begin
			if (cyclic_active || q.restore_cnt == '0)
				d.restore_win = 1'b0;
			else if (q.sw_s2 == SW_RESTORE_GO)
			begin
				d.restore_win = 1'b0;
				d.restore     = 1'b1;
			end
			else
				d.restore_cnt = q.restore_cnt - 28'h1;
		end
		// Identify flash timer, restarted by each request
		if (identify_req)
			d.ident_cnt = 28'(IDENT_LEN);
		else if (q.ident_cnt != '0)
			d.ident_cnt = q.ident_cnt - 28'h1;
		// Lamps
		d.link_lamp = q.link_s2;
		for (int i = 0; i < 2; i++)
			d.act_lamp[i] = q.restore_win ? flicker
				: (q.link_s2[i] & q.traf_s2[i] & flicker);
		if (!net_connected)
			d.bf_lamp = 1'b1;
		else if (cyclic_active)
			d.bf_lamp = 1'b0;
		else
			d.bf_lamp = flash;
		if (watchdog_timeout || system_fault || diag_pending)
			d.sf_lamp = 1'b1;
		else if (q.ident_cnt != '0)
			d.sf_lamp = flash;
		else
			d.sf_lamp = 1'b0;
		if (!q.mot_s2)
			d.mot_lamp = 1'b0;
		else if (delivery_state)
			d.mot_lamp = flash;
		else
			d.mot_lamp = 1'b1;

		// Motion command interpreter
		if (q.motion == MS_POS && target_reached)
			d.motion = MS_IDLE;
		if (cmd.valid)
		begin
			if (!rel)
			begin
				if (q.motion != MS_IDLE)
					d.abort = 1'b1;
				if (q.motion == MS_POS)
					d.aborted = 1'b1;
				d.motion = MS_IDLE;
				if (tv)
				begin
					d.target = cmd.target;
					d.loaded = 1'b1;
				end
			end
			else if (fwd ^ rev)
			begin
				if (q.motion == MS_POS)
				begin
					d.abort   = 1'b1;
					d.aborted = 1'b1;
				end
				if (q.motion != MS_MAN || q.man_fwd != fwd)
					d.start = 1'b1;
				d.motion  = MS_MAN;
				d.man_fwd = fwd;
			end
			else if (tv)
			begin
				d.target = cmd.target;
				d.loaded = 1'b0;
				d.dir_fwd = new_dir;
				if (q.motion == MS_POS)
				begin
					d.retarget = 1'b1;
					d.no_stop  = (new_dir == q.dir_fwd);
				end
				else
				begin
					d.start   = 1'b1;
					d.aborted = 1'b0;
				end
				d.motion = MS_POS;
			end
			else
			begin
				if (q.motion == MS_MAN)
				begin
					d.motion = MS_IDLE;
					d.abort  = 1'b1;
				end
				else if (q.motion == MS_IDLE && q.loaded)
				begin
					d.motion  = MS_POS;
					d.start   = 1'b1;
					d.loaded  = 1'b0;
					d.aborted = 1'b0;
					d.dir_fwd = $signed(q.target) > $signed(actual_pos);
				end
			end
		end

		// Loop run settings latched at each positioning start
		if (d.start && d.motion == MS_POS)
		begin
			d.loop_en  = loop_setting != '0;
			d.loop_fwd = ~loop_setting[15];
			d.loop_len = loop_setting;
		end
		d.status             = '0;
		d.status[SW_REACHED] = target_reached & (d.motion == MS_IDLE);
		d.status[SW_ABORTED] = d.aborted;
		d.status[SW_RUNNING] = d.motion != MS_IDLE;

		// Acyclic parameter access
		if (acyc_write.valid && acyc_write.ctrl != '0)
		begin
			d.pexec.write = 1'b1;
			d.pexec.param = acyc_write.param;
			d.pexec.value = acyc_write.value;
			d.pexec.len   = acyc_write.wide ? WR_LEN_32 : WR_LEN_16;
		end
		if (acyc_read.valid)
		begin
			d.rd_done = 1'b1;
			d.rd_len  = acyc_read.wide ? RD_LEN_32 : RD_LEN_16;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign status_word_q       = q.status;
	assign link_lamp_q         = q.link_lamp;
	assign activity_lamp_q     = q.act_lamp;
	assign bus_fault_lamp_q    = q.bf_lamp;
	assign status_fault_lamp_q = q.sf_lamp;
	assign motor_lamp_q        = q.mot_lamp;
	assign name_source_q       = q.name_src;
	assign name_number_q       = q.name_num;
	assign motion_q            = q.motion;
	assign manual_fwd_q        = q.man_fwd;
	assign target_q            = q.target;
	assign run_start_q         = q.start;
	assign run_abort_q         = q.abort;
	assign retarget_q          = q.retarget;
	assign no_stop_q           = q.no_stop;
	assign loop_enable_q       = q.loop_en;
	assign loop_fwd_q          = q.loop_fwd;
	assign loop_length_q       = q.loop_len;
	assign factory_restore_q   = q.restore;
	assign restore_window_q    = q.restore_win;
	assign param_exec_q        = q.pexec;
	assign read_done_q         = q.rd_done;
	assign read_len_q          = q.rd_len;
endmodule
`default_nettype wire

// *** design/dcl_pkg.sv ***
package dcl_pkg;

	localparam int unsigned CLK_HZ     = 25_000_000;
	localparam int unsigned FLICKER_HZ = 10;
	localparam int unsigned FLASH_HZ   = 2;
	localparam int unsigned IDENT_S    = 3;
	localparam int unsigned RESTORE_S  = 10;

	localparam int unsigned FLICKER_HALF_CYC = CLK_HZ / (2 * FLICKER_HZ);
	localparam int unsigned FLASH_HALF_CYC   = CLK_HZ / (2 * FLASH_HZ);
	localparam int unsigned IDENT_CYC        = CLK_HZ * IDENT_S;
	localparam int unsigned RESTORE_CYC      = CLK_HZ * RESTORE_S;

	localparam logic [1:0] SAMPLE_WAIT = 2'h3;

	localparam int unsigned OUT_BLOCK_BYTES = 14;
	localparam int unsigned IN_BLOCK_BYTES  = 16;

	// Control word bit positions
	localparam int unsigned CW_FWD     = 0;
	localparam int unsigned CW_REV     = 1;
	localparam int unsigned CW_TARGET  = 2;
	localparam int unsigned CW_RELEASE = 4;

	// Status word bit positions
	localparam int unsigned SW_REACHED = 0;
	localparam int unsigned SW_ABORTED = 5;
	localparam int unsigned SW_RUNNING = 6;

	localparam logic [9:0] SW_RESTORE_ARM = 10'h062;
	localparam logic [9:0] SW_RESTORE_GO  = 10'h063;

	localparam logic [2:0] WR_LEN_16 = 3'h3;
	localparam logic [2:0] WR_LEN_32 = 3'h5;
	localparam logic [2:0] RD_LEN_16 = 3'h2;
	localparam logic [2:0] RD_LEN_32 = 3'h4;

	typedef enum logic [1:0]
	{
		MS_IDLE = 2'h0,
		MS_POS  = 2'h1,
		MS_MAN  = 2'h3
	} dcl_motion_t;

	typedef enum logic [1:0]
	{
		NS_ASSIGNED = 2'h0,
		NS_SWITCH   = 2'h1,
		NS_STORED   = 2'h2
	} dcl_name_src_t;

	typedef struct packed
	{
		logic        valid;
		logic [7:0]  control;
		logic [31:0] target;
	} dcl_cmd_t;

	typedef struct packed
	{
		logic        valid;
		logic [15:0] param;
		logic [7:0]  ctrl;
		logic [31:0] value;
		logic        wide;
	} dcl_pwr_t;

	typedef struct packed
	{
		logic valid;
		logic wide;
	} dcl_prd_t;

	typedef struct packed
	{
		logic        write;
		logic [15:0] param;
		logic [31:0] value;
		logic [2:0]  len;
	} dcl_pexec_t;

	typedef struct packed
	{
		logic [27:0] cnt;
		logic        wave;
	} dcl_blink_st_t;

endpackage

// *** design/dcl_blink.sv ***
`timescale 1ns/100ps
`default_nettype none
module dcl_blink
#(
	parameter int unsigned HALF_CYC = 2
)
(
	input  wire logic clock,
	input  wire logic rst_n,
	output logic      wave_q
);
	import dcl_pkg::*;

	localparam logic [27:0] LAST = 28'(HALF_CYC - 1);

	dcl_blink_st_t q;
	dcl_blink_st_t d;

	always_comb
	begin
		d = q;
		if (q.cnt >= LAST)
		begin
			d.cnt  = '0;
			d.wave = ~q.wave;
		end
		else
		begin
			d.cnt = q.cnt + 28'h1;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign wave_q = q.wave;
endmodule
`default_nettype wire

// *** tb/dcl_plc_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module dcl_plc_model
(
	input  wire logic		clock,
	output logic			net_connected,
	output logic			cyclic_active,
	output dcl_pkg::dcl_cmd_t	cyclic_cmd
);
	import dcl_pkg::*;
	initial
	begin
		net_connected = 1'b0;
		cyclic_active = 1'b0;
		cyclic_cmd = '0;
	end
	task automatic link(input logic n, input logic c);
		@(posedge clock);
		net_connected <= n;
		cyclic_active <= c;
	endtask
	// Opens the cyclic connection before any command
	task automatic send(input logic [7:0] c, input logic [31:0] t);
		if (!cyclic_active)
			link(1'b1, 1'b1);
		@(posedge clock);
		cyclic_cmd <= '{1'b1, c, t};
		@(posedge clock);
		cyclic_cmd <= '{1'b0, ~c, ~t};
	endtask
endmodule
`default_nettype wire

// *** tb/dcl_top_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module dcl_top_asserts
(
	input wire logic			clock,
	input wire logic			rst_n,
	input wire logic			net_connected,
	input wire logic			cyclic_active,
	input wire logic			diag_pending,
	input wire logic			target_reached,
	input wire dcl_pkg::dcl_cmd_t		cyclic_cmd,
	input wire dcl_pkg::dcl_cmd_t		explicit_cmd,
	input wire dcl_pkg::dcl_pwr_t		acyc_write,
	input wire dcl_pkg::dcl_prd_t		acyc_read,
	input wire logic			bus_fault_lamp_q,
	input wire logic			status_fault_lamp_q,
	input wire dcl_pkg::dcl_motion_t	motion_q,
	input wire logic			manual_fwd_q,
	input wire logic [31:0]			target_q,
	input wire logic			run_start_q,
	input wire logic			run_abort_q,
	input wire dcl_pkg::dcl_pexec_t		param_exec_q,
	input wire logic			read_done_q,
	input wire logic [2:0]			read_len_q,
	input wire logic [15:0]			status_word_q
);
	import dcl_pkg::*;
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	logic		cc;
	logic [7:0]	cw;
	assign cc = cyclic_active && cyclic_cmd.valid && !target_reached;
	assign cw = cyclic_cmd.control;
	property p_start;
		cc && cw == 8'h14 && motion_q != MS_POS |=> run_start_q && motion_q == MS_POS
			&& target_q == $past(cyclic_cmd.target);
	endproperty
	a_start: assert property (p_start) else $error("run start wrong");
	property p_abort;
		cc && cw == 8'h00 && motion_q != MS_IDLE |=> run_abort_q && motion_q == MS_IDLE;
	endproperty
	a_abort: assert property (p_abort) else $error("abort wrong");
	property p_retarget;
		cc && cw == 8'h14 && motion_q == MS_POS |=> target_q == $past(cyclic_cmd.target);
	endproperty
	a_retarget: assert property (p_retarget) else $error("retarget wrong");
	property p_manual;
		cc && (cw == 8'h11 || cw == 8'h12) |=> motion_q == MS_MAN && manual_fwd_q == $past(cw[0]);
	endproperty
	a_manual: assert property (p_manual) else $error("manual wrong");
	property p_man_pos;
		cc && cw == 8'h11 && motion_q == MS_POS |=> run_abort_q && status_word_q[SW_ABORTED];
	endproperty
	a_man_pos: assert property (p_man_pos) else $error("manual abort wrong");
	property p_man_end;
		cc && cw == 8'h10 && motion_q == MS_MAN |=> motion_q == MS_IDLE;
	endproperty
	a_man_end: assert property (p_man_end) else $error("manual end wrong");
	property p_explicit;
		cyclic_active && explicit_cmd.valid && !cyclic_cmd.valid |=> !run_start_q && !run_abort_q;
	endproperty
	a_explicit: assert property (p_explicit) else $error("explicit taken");
	property p_write;
		acyc_write.valid |=> param_exec_q.write == ($past(acyc_write.ctrl) != 8'h00)
			&& (!param_exec_q.write
			|| param_exec_q.len == ($past(acyc_write.wide) ? WR_LEN_32 : WR_LEN_16));
	endproperty
	a_write: assert property (p_write) else $error("write wrong");
	property p_read;
		acyc_read.valid |=> read_done_q && read_len_q == ($past(acyc_read.wide) ? 3'h4 : 3'h2);
	endproperty
	a_read: assert property (p_read) else $error("read wrong");
	property p_bus_off;
		rst_n && !net_connected |=> bus_fault_lamp_q;
	endproperty
	a_bus_off: assert property (p_bus_off) else $error("bus lamp wrong");
	property p_diag;
		diag_pending |=> status_fault_lamp_q;
	endproperty
	a_diag: assert property (p_diag) else $error("status lamp wrong");
	c_start: cover property (cc && cw == 8'h14);
	c_abort: cover property (run_abort_q);
	c_write: cover property (param_exec_q.write);
endmodule
bind dcl_top dcl_top_asserts u_chk (.clock, .rst_n, .net_connected, .cyclic_active,
	.diag_pending, .target_reached, .cyclic_cmd, .explicit_cmd, .acyc_write, .acyc_read,
	.bus_fault_lamp_q, .status_fault_lamp_q, .motion_q, .manual_fwd_q, .target_q,
	.run_start_q, .run_abort_q, .param_exec_q, .read_done_q, .read_len_q, .status_word_q);
`default_nettype wire

// *** tb/dcl_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module dcl_top_tb;
	import dcl_pkg::*;
	logic		clock = 1'b0, rst_n = 1'b0, switches_fitted = 1'b0, motor_supply_ok = 1'b0;
	logic		identify_req = 1'b0, diag_pending = 1'b0, delivery_state = 1'b0;
	logic		target_reached = 1'b0, net_connected, cyclic_active, bus_fault_lamp_q;
	logic		status_fault_lamp_q, motor_lamp_q, manual_fwd_q, run_start_q, run_abort_q;
	logic		retarget_q, no_stop_q, loop_enable_q, loop_fwd_q, factory_restore_q;
	logic		restore_window_q, read_done_q, watchdog_timeout = 1'b0;
	logic [9:0]	switch_value = 10'h000;
	logic [1:0]	port_link = 2'h0, port_traffic = 2'h0, link_lamp_q, activity_lamp_q;
	logic [15:0]	stored_address = 16'h0000, loop_setting = 16'hFFFB;
	logic [15:0]	name_number_q, status_word_q, loop_length_q;
	logic [31:0]	actual_pos = 32'h0, target_q;
	logic [2:0]	read_len_q;
	dcl_cmd_t	explicit_cmd = '0, cyclic_cmd;
	dcl_pwr_t	acyc_write = '0;
	dcl_prd_t	acyc_read = '0;
	dcl_name_src_t	name_source_q;
	dcl_motion_t	motion_q;
	dcl_pexec_t	param_exec_q;
	int		mismatches = 0;
	int		checks = 0;

	always #20 clock = ~clock;

	dcl_plc_model plc (.clock, .net_connected, .cyclic_active, .cyclic_cmd);
	dcl_top #(.FLICKER_HALF(4), .FLASH_HALF(8), .IDENT_LEN(100), .RESTORE_LEN(200)) DUT
	(
		.clock, .rst_n, .switches_fitted, .switch_value, .port_link, .port_traffic,
		.motor_supply_ok, .net_connected, .cyclic_active, .identify_req,
		.watchdog_timeout, .system_fault(1'b0), .diag_pending, .delivery_state,
		.stored_address, .cyclic_cmd, .explicit_cmd, .actual_pos, .target_reached,
		.loop_setting, .acyc_write, .acyc_read, .link_lamp_q, .activity_lamp_q,
		.bus_fault_lamp_q, .status_fault_lamp_q, .motor_lamp_q, .name_source_q,
		.name_number_q, .motion_q, .manual_fwd_q, .target_q, .run_start_q, .run_abort_q,
		.retarget_q, .no_stop_q, .loop_enable_q, .loop_fwd_q, .loop_length_q,
		.factory_restore_q, .restore_window_q, .status_word_q, .param_exec_q,
		.read_done_q, .read_len_q
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic por(input logic f, input logic [9:0] v, input logic [15:0] s);
		@(posedge clock);
		rst_n <= 1'b0;
		switches_fitted <= f;
		switch_value <= v;
		stored_address <= s;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		wt(7);
	endtask
	task automatic cs(input logic [7:0] c, input logic [31:0] t);
		plc.send(c, t);
		@(negedge clock);
	endtask
	task automatic xs(input logic [7:0] c, input logic [31:0] t);
		@(posedge clock);
		explicit_cmd <= '{1'b1, c, t};
		@(posedge clock);
		explicit_cmd <= '{1'b0, ~c, ~t};
		@(negedge clock);
	endtask
	task automatic awr(input logic [7:0] c, input logic w);
		@(posedge clock);
		acyc_write <= '{1'b1, 16'h002A, c, 32'h0000_1234, w};
		@(posedge clock);
		acyc_write.valid <= 1'b0;
		@(negedge clock);
	endtask
	task automatic hic(input int s, input logic [31:0] e);
		int n = 0;
		repeat (2 * e)
		begin
			@(negedge clock);
			n += (s == 0) ? bus_fault_lamp_q : (s == 1) ? activity_lamp_q[0]
				: (s == 2) ? status_fault_lamp_q : motor_lamp_q;
		end
		chk(32'(n), e);
	endtask

	initial
	begin
		por(1'b1, 10'h02A, 16'h0007);
		chk({name_source_q, name_number_q}, {NS_SWITCH, 16'h002A});
		chk(motor_lamp_q, 1'b0);
		@(posedge clock);
		switch_value <= 10'h005;
		wt(6);
		chk(name_number_q, 16'h002A);
		por(1'b0, 10'h02A, 16'h0123);
		chk({name_source_q, name_number_q}, {NS_STORED, 16'h0123});
		por(1'b1, 10'h000, 16'h0000);
		chk({name_source_q, restore_window_q}, {NS_ASSIGNED, 1'b0});
		por(1'b1, 10'h062, 16'h0000);
		chk(restore_window_q, 1'b1);
		hic(1, 32'd8);
		@(posedge clock);
		switch_value <= 10'h063;
		for (int i = 0; i < 20 && factory_restore_q !== 1'b1; i++)
			@(negedge clock);
		chk(factory_restore_q, 1'b1);
		wt(1);
		chk(restore_window_q, 1'b0);
		por(1'b1, 10'h062, 16'h0000);
		plc.link(1'b1, 1'b1);
		wt(2);
		chk(restore_window_q, 1'b0);
		cs(8'h14, 32'd100);
		chk({motion_q, run_start_q, status_word_q[SW_RUNNING]}, {MS_POS, 2'b11});
		chk(target_q, 32'd100);
		chk({loop_enable_q, loop_fwd_q, loop_length_q}, {2'b10, 16'hFFFB});
		cs(8'h14, 32'd200);
		chk({retarget_q, no_stop_q, motion_q}, {2'b11, MS_POS});
		cs(8'h14, 32'hFFFF_FFCE);
		chk({retarget_q, no_stop_q}, 2'b10);
		cs(8'h11, 32'd0);
		chk({motion_q, manual_fwd_q, run_abort_q, status_word_q[SW_ABORTED]}, {MS_MAN, 3'h7});
		cs(8'h12, 32'd0);
		chk({motion_q, manual_fwd_q, run_start_q}, {MS_MAN, 2'b01});
		cs(8'h14, 32'd300);
		chk({motion_q, run_start_q}, {MS_POS, 1'b1});
		cs(8'h00, 32'd0);
		chk({motion_q, run_abort_q, status_word_q[SW_ABORTED]}, {MS_IDLE, 2'b11});
		cs(8'h04, 32'd400);
		chk({motion_q, run_start_q}, {MS_IDLE, 1'b0});
		cs(8'h10, 32'd0);
		chk({motion_q, run_start_q}, {MS_POS, 1'b1});
		chk(target_q, 32'd400);
		@(posedge clock);
		target_reached <= 1'b1;
		wt(3);
		chk({motion_q, status_word_q}, {MS_IDLE, 16'h0001});
		@(posedge clock);
		target_reached <= 1'b0;
		cs(8'h11, 32'd0);
		cs(8'h10, 32'd0);
		chk({motion_q, run_abort_q}, {MS_IDLE, 1'b1});
		xs(8'h14, 32'd5);
		chk(motion_q, MS_IDLE);
		plc.link(1'b1, 1'b0);
		xs(8'h14, 32'd5);
		chk(motion_q, MS_POS);
		chk(target_q, 32'd5);
		hic(0, 32'd16);
		plc.link(1'b1, 1'b1);
		wt(2);
		chk(bus_fault_lamp_q, 1'b0);
		@(posedge clock);
		port_link <= 2'b01;
		port_traffic <= 2'b01;
		identify_req <= 1'b1;
		@(posedge clock);
		identify_req <= 1'b0;
		wt(4);
		chk({link_lamp_q, activity_lamp_q[1]}, 3'b010);
		hic(1, 32'd8);
		hic(2, 32'd16);
		wt(100);
		chk(status_fault_lamp_q, 1'b0);
		@(posedge clock);
		diag_pending <= 1'b1;
		motor_supply_ok <= 1'b1;
		wt(4);
		chk({status_fault_lamp_q, motor_lamp_q}, 2'b11);
		@(posedge clock);
		diag_pending <= 1'b0;
		watchdog_timeout <= 1'b1;
		delivery_state <= 1'b1;
		wt(3);
		chk(status_fault_lamp_q, 1'b1);
		hic(3, 32'd16);
		awr(8'h00, 1'b1);
		chk(param_exec_q.write, 1'b0);
		awr(8'h01, 1'b1);
		chk({param_exec_q.write, param_exec_q.len, param_exec_q.value[15:0]}, 20'hD1234);
		awr(8'h01, 1'b0);
		chk({param_exec_q.write, param_exec_q.len}, 4'hB);
		@(posedge clock);
		acyc_read <= '{1'b1, 1'b1};
		@(posedge clock);
		acyc_read.valid <= 1'b0;
		@(negedge clock);
		chk({read_done_q, read_len_q}, 4'hC);
		final_report();
	end

	initial
	begin
		#(40 * 6000);
		mismatches++;
		final_report();
	end
endmodule
`default_nettype wire
